/* logic/xpcl_host.sv */
/*
 * Host end: on a load pulse shifts 256 bits out MSB (row 15 col 15) first
 * using a divided shift clock, then pulses the strobe low. Captures serial_out.
 * Assumes link pins come from another clock domain.
 */
`include "xpcl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module xpcl_host
	import xpcl_pkg::*;
#(
	parameter int HALF_CYC   = `XPCL_SCLK_HALF_CYC,
	parameter int STROBE_CYC = `XPCL_STROBE_LOW_CYC
)
(
	input  wire logic    core_clk,
	input  wire logic    rstn,
	input  wire logic    load_start,
	input  wire xpcl_matrix_t load_data,
	output logic         busy,
	output logic         done,
	output xpcl_matrix_t readback,
	xpcl_link_if.host    link
);
	xpcl_host_state_t state_reg, state_next;
	xpcl_matrix_t data_reg, data_next, rb_reg, rb_next;
	logic [8:0] bit_reg, bit_next;
	logic [7:0] tick_reg, tick_next;
	logic sclk_reg, sclk_next, sin_reg, sin_next, strb_reg, strb_next;
	logic done_reg, done_next;
	logic [1:0] serial_out_sync_reg, serial_out_sync_next;
	// one stage per cycle of round trip: device sync 2, its register 1, our sync 2, plus one
	logic [5:0] cap_reg, cap_next;
	logic busy_reg, busy_next;

	always_comb
	begin
		state_next = state_reg;
		data_next  = data_reg;
		rb_next    = rb_reg;
		bit_next   = bit_reg;
		tick_next  = tick_reg;
		sclk_next  = sclk_reg;
		sin_next   = sin_reg;
		strb_next  = strb_reg;
		done_next  = 1'b0;
		serial_out_sync_next = {serial_out_sync_reg[0], link.serial_out};
		cap_next   = {cap_reg[4:0], 1'b0};
		case (state_reg)
			XPCL_IDLE:
				if (load_start)
				begin
					data_next  = load_data;
					sin_next   = load_data[`XPCL_BITS-1];
					bit_next   = 9'h000;
					tick_next  = 8'h00;
					state_next = XPCL_SHIFT;
				end
			XPCL_SHIFT:
				if (tick_reg == 8'(HALF_CYC - 1))
				begin
					tick_next = 8'h00;
					sclk_next = ~sclk_reg;
					if (sclk_reg)
					begin
						// falling edge: present next bit
						data_next = {data_reg[`XPCL_BITS-2:0], 1'b0};
						sin_next  = data_reg[`XPCL_BITS-2];
						if (bit_reg == 9'(`XPCL_BITS))
						begin
							state_next = XPCL_STROBE;
							strb_next  = 1'b0;
						end
					end
					else
					begin
						cap_next[0] = 1'b1;
						bit_next = bit_reg + 9'h001;
					end
				end
				else
					tick_next = tick_reg + 8'h01;
			XPCL_STROBE:
				// strobe follows loading at once, far inside 5 ms
				if (tick_reg == 8'(STROBE_CYC))
				begin
					strb_next  = 1'b1;
					tick_next  = 8'h00;
					state_next = XPCL_GAP;
				end
				else
					tick_next = tick_reg + 8'h01;
			XPCL_GAP:
			begin
				done_next  = 1'b1;
				state_next = XPCL_IDLE;
			end
			default:
				state_next = XPCL_IDLE;
		endcase
		// a rise's serial_out is back here six cycles later, too late for the next rise;
		// the last capture lands no later than done while HALF_CYC + STROBE_CYC >= 4
		if (cap_reg[5])
			rb_next = {rb_reg[`XPCL_BITS-2:0], serial_out_sync_reg[1]};
		busy_next = (state_next != XPCL_IDLE);
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= XPCL_IDLE;
			data_reg  <= '0;
			rb_reg    <= '0;
			bit_reg   <= 9'h000;
			tick_reg  <= 8'h00;
			sclk_reg  <= 1'b0;
			sin_reg   <= 1'b0;
			strb_reg  <= 1'b1;
			done_reg  <= 1'b0;
			serial_out_sync_reg <= 2'h0;
			cap_reg   <= 6'h00;
			busy_reg  <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			data_reg  <= data_next;
			rb_reg    <= rb_next;
			bit_reg   <= bit_next;
			tick_reg  <= tick_next;
			sclk_reg  <= sclk_next;
			sin_reg   <= sin_next;
			strb_reg  <= strb_next;
			done_reg  <= done_next;
			serial_out_sync_reg <= serial_out_sync_next;
			cap_reg   <= cap_next;
			busy_reg  <= busy_next;
		end
	end

	assign busy     = busy_reg;
	assign done     = done_reg;
	assign readback = rb_reg;
	assign link.shift_clock    = sclk_reg;
	assign link.serial_in      = sin_reg;
	assign link.latch_strobe_n = strb_reg;
endmodule

`default_nettype wire

/* pkg/xpcl_params.svh */
/*
 * Constants for the crosspoint serial configuration loader: array size and
 * link timing. Assumes a 20 MHz core clock; included by both ends and the package.
 */
`ifndef XPCL_PARAMS_SVH
`define XPCL_PARAMS_SVH

`define XPCL_ROWS            16
`define XPCL_COLS            16
`define XPCL_BITS            256
`define XPCL_CORE_CLK_HZ     20000000
`define XPCL_SHIFT_MIN_HZ    20000
`define XPCL_LATCH_MAX_MS    5
`define XPCL_SCLK_HALF_NS    100
`define XPCL_STROBE_LOW_NS   65
`define XPCL_CORE_PERIOD_NS  50
// least times round up, longest round down
`define XPCL_SCLK_HALF_CYC   ((`XPCL_SCLK_HALF_NS + `XPCL_CORE_PERIOD_NS - 1) / `XPCL_CORE_PERIOD_NS)
`define XPCL_STROBE_LOW_CYC  ((`XPCL_STROBE_LOW_NS + `XPCL_CORE_PERIOD_NS - 1) / `XPCL_CORE_PERIOD_NS)
`define XPCL_SHIFT_MAX_CYC   (`XPCL_CORE_CLK_HZ / `XPCL_SHIFT_MIN_HZ)
`define XPCL_LATCH_MAX_CYC   ((`XPCL_CORE_CLK_HZ / 1000) * `XPCL_LATCH_MAX_MS)

`endif

/* pkg/xpcl_pkg.sv */
/*
 * Types for the crosspoint loader. Assumes xpcl_params.svh on the include path.
 */
`include "xpcl_params.svh"

package xpcl_pkg;
	typedef logic [`XPCL_BITS-1:0] xpcl_matrix_t;

	typedef enum logic [3:0] {
		XPCL_IDLE   = 4'h1,
		XPCL_SHIFT  = 4'h2,
		XPCL_STROBE = 4'h4,
		XPCL_GAP    = 4'h8
	} xpcl_host_state_t;
endpackage

/* pkg/xpcl_link_if.sv */
/*
 * Link between host controller and crosspoint device: serial clock, data in,
 * latch strobe, data out. Assumes both ends are plain logic, no tristate.
 */
`timescale 1ns/1ps
`default_nettype none

interface xpcl_link_if;
	logic shift_clock;
	logic serial_in;
	logic latch_strobe_n;
	logic serial_out;

	modport device
	(
		input  shift_clock,
		input  serial_in,
		input  latch_strobe_n,
		output serial_out
	);

	modport host
	(
		output shift_clock,
		output serial_in,
		output latch_strobe_n,
		input  serial_out
	);
endinterface

`default_nettype wire

/* logic/xpcl_device.sv */
/*
 * Crosspoint device end: 256-bit shift register clocked by sampled edges of
 * shift_clock, latches copied while the strobe is low, switch controls out.
 * Assumes link pins are asynchronous to core_clk and slow against it.
 */
// Operation
// - sample serial_in on each shift_clock rise
// - first bit controls row 15 column 15
// - serial_out shows bit from 256 clocks earlier
// - serial_out is non-inverted
// - host shifts 256 bits before strobing
// - strobe low copies register into latches
// - host strobes within 5 ms after loading
// - host shift clock at least 20 kHz
// - latches hold until next strobe
// - devices may be chained out to in
`include "xpcl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module xpcl_device
	import xpcl_pkg::*;
(
	input  wire logic   core_clk,
	input  wire logic   rstn,
	xpcl_link_if.device link,
	output xpcl_matrix_t switch_closed
);
	logic [2:0] sclk_sync_reg, sclk_sync_next;
	logic [1:0] sin_sync_reg, sin_sync_next;
	logic [1:0] strb_sync_reg, strb_sync_next;
	xpcl_matrix_t shift_reg, shift_next;
	xpcl_matrix_t latch_reg, latch_next;
	logic serial_out_reg, serial_out_next;
	logic sclk_rise;

	always_comb
	begin
		sclk_sync_next = {sclk_sync_reg[1:0], link.shift_clock};
		sin_sync_next  = {sin_sync_reg[0], link.serial_in};
		strb_sync_next = {strb_sync_reg[0], link.latch_strobe_n};
		// edge taken from stages two and three, never the first
		sclk_rise  = sclk_sync_reg[1] & ~sclk_sync_reg[2];
		shift_next = shift_reg;
		latch_next = latch_reg;
		serial_out_next  = serial_out_reg;
		if (sclk_rise)
		begin
			// bit 255 is the oldest; after 256 shifts it holds row 15 column 15
			shift_next = {shift_reg[`XPCL_BITS-2:0], sin_sync_reg[1]};
			serial_out_next  = shift_reg[`XPCL_BITS-1];
		end
		if (!strb_sync_reg[1])
			latch_next = shift_reg;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sclk_sync_reg <= 3'h0;
			sin_sync_reg  <= 2'h0;
			strb_sync_reg <= 2'h3;
			shift_reg     <= '0;
			latch_reg     <= '0;
			serial_out_reg      <= 1'h0;
		end
		else
		begin
			sclk_sync_reg <= sclk_sync_next;
			sin_sync_reg  <= sin_sync_next;
			strb_sync_reg <= strb_sync_next;
			shift_reg     <= shift_next;
			latch_reg     <= latch_next;
			serial_out_reg      <= serial_out_next;
		end
	end

	// index row*16+col: one closes the switch
	assign switch_closed  = latch_reg;
	// chaining works since serial_out is a plain register output
	assign link.serial_out = serial_out_reg;
endmodule

`default_nettype wire

/* bench/xpcl_assertions.sv */
/* link checker: shift clock shape, strobe shape, output quiet time.
 assumes host HALF_CYC 2 and STROBE_CYC 2 */
`timescale 1ns/1ps
`default_nettype none
module xpcl_assertions
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic shift_clock,
	input wire logic serial_in,
	input wire logic latch_strobe_n,
	input wire logic serial_out
);
	logic [2:0] age_reg;
	logic [2:0] age_next;
	always_comb
		age_next = shift_clock ? 3'h0 : (age_reg == 3'h7 ? age_reg : age_reg + 3'h1);
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			age_reg <= 3'h7;
		else
			age_reg <= age_next;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sclk_width_a: assert property ($rose(shift_clock) |-> shift_clock[*2] ##1 !shift_clock)
		else $error("shift clock high time wrong");
	data_hold_a: assert property (shift_clock |-> $stable(serial_in))
		else $error("data moved while shift clock high");
	sclk_rate_a: assert property ($fell(shift_clock) |-> ##[0:999] ($rose(shift_clock) || $fell(latch_strobe_n)))
		else $error("shift clock too slow");
	strobe_width_a: assert property ($fell(latch_strobe_n) |-> !latch_strobe_n[*3])
		else $error("strobe too short");
	strobe_release_a: assert property ($fell(latch_strobe_n) |-> ##[3:8] latch_strobe_n)
		else $error("strobe not released");
	strobe_quiet_a: assert property (!latch_strobe_n |-> !shift_clock)
		else $error("shifting during strobe");
	out_quiet_a: assert property ($changed(serial_out) |-> age_reg < 3'h4)
		else $error("serial out moved without shift");
	cover property ($fell(latch_strobe_n));
	cover property ($changed(serial_out));
	cover property ($rose(shift_clock) && serial_in);
endmodule
`default_nettype wire

/* bench/test_crosspoint_serial_config_loader.sv */
/* bench: host and device joined by the link, patterns loaded and compared
 with a queue model. assumes a 20 MHz core clock */
`timescale 1ns/1ps
`default_nettype none
module test_crosspoint_serial_config_loader
	import xpcl_pkg::*;
;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic load_start = 1'b0;
	logic busy, done;
	xpcl_matrix_t load_data = '0;
	xpcl_matrix_t readback, switch_closed, d;
	xpcl_matrix_t q[$];
	int errors = 0, checks_done = 0, cyc = 0, n;
	int seed = 32'hB8703981;
	xpcl_link_if link();
	xpcl_host i_xpcl_host (.core_clk(core_clk), .rstn(rstn), .load_start(load_start), .load_data(load_data),
		.busy(busy), .done(done), .readback(readback), .link(link));
	xpcl_device i_xpcl_device (.core_clk(core_clk), .rstn(rstn), .link(link), .switch_closed(switch_closed));
	xpcl_assertions i_xpcl_assertions (.core_clk(core_clk), .rstn(rstn), .shift_clock(link.shift_clock),
		.serial_in(link.serial_in), .latch_strobe_n(link.latch_strobe_n), .serial_out(link.serial_out));
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			errors++;
			end_of_test();
		end
	end
	task automatic check(input xpcl_matrix_t seen, input xpcl_matrix_t exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d checks_done %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		q.push_back('0);
		repeat (4) @(negedge core_clk);
		rstn = 1'b1;
		for (int k = 0; k < 7; k++)
		begin
			for (int i = 0; i < 8; i++)
				d[i*32 +: 32] = $random(seed);
			d = k == 0 ? '1 : k == 1 ? {1'b1, 255'h0} : k == 2 ? 256'h1 : d;
			@(negedge core_clk);
			load_data = d;
			load_start = 1'b1;
			@(negedge core_clk);
			load_start = 1'b0;
			// a second start while busy must be ignored
			repeat (500) @(negedge core_clk);
			load_data = ~d;
			load_start = 1'b1;
			@(negedge core_clk);
			load_start = 1'b0;
			// mid-load: old settings must still drive the switches
			repeat (499) @(negedge core_clk);
			check(switch_closed, q[$]);
			check(busy, 256'h1);
			for (n = 0; n < 4000 && done !== 1'b1; n++)
				@(negedge core_clk);
			check(done, 256'h1);
			repeat (4) @(negedge core_clk);
			check(switch_closed, d);
			check(readback, q[$]);
			check(busy, 256'h0);
			q.push_back(d);
		end
		repeat (50) @(negedge core_clk);
		check(switch_closed, q[$]);
		end_of_test();
	end
endmodule
`default_nettype wire
